// >>> src/kms_regs.vh
`ifndef KMS_REGS_VH
`define KMS_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define KMS_ADDR_CTRL1       8'hC0
`define KMS_ADDR_CTRL2       8'hC1
`define KMS_ADDR_CODE0       8'hC2
`define KMS_ADDR_CODE1       8'hC3
`define KMS_ADDR_CODE2       8'hC4
`define KMS_ADDR_EXTRA_IO    8'hC7
`define KMS_ADDR_EVT_STATUS  8'hC8
`define KMS_ADDR_EVT_MASK    8'hC9
`define KMS_ADDR_INT_CTRL1   8'hF0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define KMS_C1_SCAN_EN       7
`define KMS_C1_LONG_EN       6
`define KMS_C1_DEB_HI        5
`define KMS_C1_DEB_LO        4
`define KMS_C1_FREQ_HI       2
`define KMS_C1_FREQ_LO       0
`define KMS_C1_WMASK         8'hF7
`define KMS_C2_WAKE_EN       7
`define KMS_C2_LONG_HI       3
`define KMS_C2_LONG_LO       2
`define KMS_C2_CNT_HI        1
`define KMS_C2_CNT_LO        0
`define KMS_IO_BIT           0
`define KMS_EVT_PRESS        0
`define KMS_EVT_LONG         1
`define KMS_EVT_W            2
`define KMS_INTC_KEY_EN      4

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define KMS_RST_BYTE         8'h00
`define KMS_RST_EVT          2'h0
`define KMS_DEB_BASE         6'h04
`define KMS_MAX_KEYS         2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define KMS_CLK_PERIOD_NS    25
`define KMS_SCAN_BASE_NS     64000
`define KMS_LONG_BASE_MS     625
`define KMS_NS_PER_MS        1000000

`endif

// >>> src/kms_scan_timer.v
`timescale 1ns/1ps
module kms_scan_timer #(
  parameter SLOT_CYC = 640,
  parameter CNT_W    = 20
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire             ce,
  input  wire             run,
  input  wire [2:0]       freq_sel,
  output reg              slot_tick_r
);

  reg  [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] slot_len;
  wire [CNT_W-1:0] last_cnt;

  // Each step of the frequency select doubles the slot
  assign slot_len = SLOT_CYC[CNT_W-1:0] << freq_sel; // R1
  assign last_cnt = slot_len - {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r       <= {CNT_W{1'b0}};
      slot_tick_r <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r       <= {CNT_W{1'b0}};
        slot_tick_r <= 1'b0;
      end else if (cnt_r >= last_cnt) begin
        cnt_r       <= {CNT_W{1'b0}};
        slot_tick_r <= 1'b1;
      end else begin
        cnt_r       <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        slot_tick_r <= 1'b0;
      end
    end
  end

endmodule // kms_scan_timer

// >>> src/kms_top.v
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "kms_regs.vh"

//Operation
// (R1) Three-bit frequency field doubles scan cycle per step, 64us to 8.192ms.
// (R2) With long-key enabled, flag long press after hold time from timing field.
// (R3) Wake-up enable bit lets a key press wake the device from low power.
// (R4) Two-bit read-only count of pressed keys, zero to three.
// (R5) First pressed key code in read-only register, no defined reset value.
// (R6) Second and third key codes valid only when count says so.
// (R7) Extra I/O bit reads input pin level, write drives output pin.
// (R8) Scan only while enabled; accept state after debounce-selected stable scans.
// (R9) Key-scan interrupt raised only while interrupt enable bit 4 is set.
module kms_top #(
  parameter ROWS          = 4,
  parameter COLS          = 5,
  parameter SCAN_BASE_CYC = `KMS_SCAN_BASE_NS / `KMS_CLK_PERIOD_NS,
  parameter LONG_BASE_CYC = (`KMS_LONG_BASE_MS * `KMS_NS_PER_MS) / `KMS_CLK_PERIOD_NS
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire             ce,
  input  wire [7:0]       addr,
  input  wire [7:0]       wr_data,
  input  wire             wr_stb,
  input  wire             rd_stb,
  output reg  [7:0]       rd_data_r,
  output reg  [ROWS-1:0]  key_row_n_r,
  input  wire [COLS-1:0]  key_col_n,
  input  wire             extra_input_pin,
  output reg              extra_output_pin_r,
  input  wire             sleep_mode,
  output reg              wake_req_r,
  output reg              irq_r
);

  // --------------------------------------------------------------------------
  // Local constants
  // --------------------------------------------------------------------------
  localparam KEYS  = ROWS * COLS;
  localparam SLOT  = SCAN_BASE_CYC / ROWS;
  localparam RW    = 2;

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg  [7:0]      ctrl1_r;
  reg             wake_en_r;
  reg  [1:0]      long_sel_r;
  reg  [1:0]      key_cnt_r;
  reg  [7:0]      code0_r;
  reg  [7:0]      code1_r;
  reg  [7:0]      code2_r;
  reg  [`KMS_EVT_W-1:0] evt_status_r;
  reg  [`KMS_EVT_W-1:0] evt_mask_r;
  reg             int_key_en_r;

  wire            scan_en  = ctrl1_r[`KMS_C1_SCAN_EN];
  wire            long_en  = ctrl1_r[`KMS_C1_LONG_EN];
  wire [1:0]      deb_sel  = ctrl1_r[`KMS_C1_DEB_HI:`KMS_C1_DEB_LO];
  wire [2:0]      freq_sel = ctrl1_r[`KMS_C1_FREQ_HI:`KMS_C1_FREQ_LO];

  // --------------------------------------------------------------------------
  // Scan engine
  // --------------------------------------------------------------------------
  reg  [RW-1:0]   row_r;
  reg  [KEYS-1:0] snap_r;
  reg  [KEYS-1:0] last_r;
  reg  [KEYS-1:0] deb_r;
  reg  [5:0]      stable_r;
  reg  [31:0]     long_cnt_r;
  reg             long_done_r;
  wire            slot_tick;
  reg  [KEYS-1:0] snap_nxt;
  reg  [5:0]      stable_nxt;
  wire            scan_done;
  wire            accept;
  wire            press_evt;
  wire            long_evt;
  wire [5:0]      deb_thr;
  wire [31:0]     long_lim;

  // --------------------------------------------------------------------------
  // Key code of a matrix position
  // --------------------------------------------------------------------------

  function [7:0] kms_code;
    input [7:0] idx;
    reg   [7:0] r;
    reg   [7:0] c;
    begin
      r        = idx / COLS;
      c        = idx % COLS;
      kms_code = {r[3:0], c[3:0]};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Row slot timer
  // --------------------------------------------------------------------------

  kms_scan_timer #(
    .SLOT_CYC (SLOT),
    .CNT_W    (20)
  ) u_timer (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .ce          (ce),
    .run         (scan_en),
    .freq_sel    (freq_sel),
    .slot_tick_r (slot_tick)
  );

  // Columns of the driven row are sampled at the end of its slot
  genvar gc;
  generate
    for (gc = 0; gc < KEYS; gc = gc + 1) begin : g_snap
      always @* begin
        if ((gc / COLS) == row_r)
          snap_nxt[gc] = ~key_col_n[gc % COLS];
        else
          snap_nxt[gc] = snap_r[gc];
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Debounce of full scans
  // --------------------------------------------------------------------------

  assign scan_done = slot_tick && (row_r == ROWS - 1);
  assign deb_thr   = `KMS_DEB_BASE << deb_sel;

  always @* begin
    if (snap_nxt != last_r)
      stable_nxt = 6'h01;
    else if (stable_r < deb_thr)
      stable_nxt = stable_r + 6'h01;
    else
      stable_nxt = stable_r;
  end

  // --------------------------------------------------------------------------
  // Acceptance and long press
  // --------------------------------------------------------------------------

  assign accept    = scan_done && (stable_nxt >= deb_thr) && (snap_nxt != deb_r); // R8
  assign press_evt = accept && ((snap_nxt & ~deb_r) != {KEYS{1'b0}});
  assign long_lim  = LONG_BASE_CYC * ({30'h0000_0000, long_sel_r} + 32'h0000_0001);
  assign long_evt  = long_en && !long_done_r && (deb_r != {KEYS{1'b0}}) && !accept
                     && (long_cnt_r + 32'h0000_0001 >= long_lim); // R2

  // --------------------------------------------------------------------------
  // Scan and hold registers
  // --------------------------------------------------------------------------

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      row_r       <= {RW{1'b0}};
      key_row_n_r <= {ROWS{1'b1}};
      snap_r      <= {KEYS{1'b0}};
      last_r      <= {KEYS{1'b0}};
      deb_r       <= {KEYS{1'b0}};
      stable_r    <= 6'h00;
      long_cnt_r  <= 32'h0000_0000;
      long_done_r <= 1'b0;
    end else if (ce) begin
      if (!scan_en) begin
        row_r       <= {RW{1'b0}};
        key_row_n_r <= {ROWS{1'b1}}; // R8
        stable_r    <= 6'h00;
      end else begin
        key_row_n_r <= ~({{(ROWS-1){1'b0}}, 1'b1} << row_r);
        if (slot_tick) begin
          snap_r <= snap_nxt;
          row_r  <= (row_r == ROWS - 1) ? {RW{1'b0}} : row_r + {{(RW-1){1'b0}}, 1'b1};
          key_row_n_r <= ~({{(ROWS-1){1'b0}}, 1'b1} <<
                          ((row_r == ROWS - 1) ? {RW{1'b0}} : row_r + {{(RW-1){1'b0}}, 1'b1}));
        end
        if (scan_done) begin
          last_r   <= snap_nxt;
          stable_r <= stable_nxt; // R8
        end
        if (accept)
          deb_r <= snap_nxt;
      end
      // Hold timer restarts on every change of the accepted state
      if (accept || !long_en || deb_r == {KEYS{1'b0}}) begin
        long_cnt_r  <= 32'h0000_0000;
        long_done_r <= 1'b0;
      end else if (long_evt) begin
        long_done_r <= 1'b1;
      end else if (!long_done_r) begin
        long_cnt_r  <= long_cnt_r + 32'h0000_0001; // R2
      end
    end
  end

  // --------------------------------------------------------------------------
  // Key code extraction
  // --------------------------------------------------------------------------
  reg  [7:0] c0_nxt;
  reg  [7:0] c1_nxt;
  reg  [7:0] c2_nxt;
  reg  [1:0] cnt_nxt;
  integer    i;

  always @* begin
    c0_nxt  = code0_r;
    c1_nxt  = code1_r;
    c2_nxt  = code2_r;
    cnt_nxt = 2'h0;
    for (i = 0; i < KEYS; i = i + 1) begin
      if (snap_nxt[i] && cnt_nxt != `KMS_MAX_KEYS) begin
        case (cnt_nxt)
          2'h0:    c0_nxt = kms_code(i[7:0]);
          2'h1:    c1_nxt = kms_code(i[7:0]);
          default: c2_nxt = kms_code(i[7:0]);
        endcase
        cnt_nxt = cnt_nxt + 2'h1;
      end
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      key_cnt_r <= 2'h0;
      code0_r   <= `KMS_RST_BYTE;
      code1_r   <= `KMS_RST_BYTE;
      code2_r   <= `KMS_RST_BYTE;
    end else if (ce && accept) begin
      key_cnt_r <= cnt_nxt; // R4
      code0_r   <= c0_nxt; // R5
      code1_r   <= c1_nxt; // R6
      code2_r   <= c2_nxt; // R6
    end
  end

  // --------------------------------------------------------------------------
  // Register bus, events and interrupt
  // --------------------------------------------------------------------------
  wire                  rd_status = rd_stb && (addr == `KMS_ADDR_EVT_STATUS);
  wire [`KMS_EVT_W-1:0] evt_set;
  reg  [7:0]            rd_mux;

  assign evt_set[`KMS_EVT_PRESS] = press_evt;
  assign evt_set[`KMS_EVT_LONG]  = long_evt;

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------

  always @* begin
    case (addr)
      `KMS_ADDR_CTRL1:      rd_mux = ctrl1_r;
      `KMS_ADDR_CTRL2:      rd_mux = {wake_en_r, 3'h0, long_sel_r, key_cnt_r}; // R4
      `KMS_ADDR_CODE0:      rd_mux = code0_r;
      `KMS_ADDR_CODE1:      rd_mux = code1_r;
      `KMS_ADDR_CODE2:      rd_mux = code2_r;
      `KMS_ADDR_EXTRA_IO:   rd_mux = {7'h00, extra_input_pin}; // R7
      `KMS_ADDR_EVT_STATUS: rd_mux = {6'h00, evt_status_r};
      `KMS_ADDR_EVT_MASK:   rd_mux = {6'h00, evt_mask_r};
      `KMS_ADDR_INT_CTRL1:  rd_mux = {3'h0, int_key_en_r, 4'h0};
      default:              rd_mux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Register writes, read data and interrupt
  // --------------------------------------------------------------------------

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl1_r            <= `KMS_RST_BYTE;
      wake_en_r          <= 1'b0;
      long_sel_r         <= 2'h0;
      evt_mask_r         <= `KMS_RST_EVT;
      int_key_en_r       <= 1'b0;
      extra_output_pin_r <= 1'b0;
      evt_status_r       <= `KMS_RST_EVT;
      rd_data_r          <= 8'h00;
      irq_r              <= 1'b0;
      wake_req_r         <= 1'b0;
    end else if (ce) begin
      if (wr_stb) begin
        case (addr)
          `KMS_ADDR_CTRL1: ctrl1_r <= wr_data & `KMS_C1_WMASK; // R1
          `KMS_ADDR_CTRL2: begin
            wake_en_r  <= wr_data[`KMS_C2_WAKE_EN];
            long_sel_r <= wr_data[`KMS_C2_LONG_HI:`KMS_C2_LONG_LO];
          end
          `KMS_ADDR_EXTRA_IO:  extra_output_pin_r <= wr_data[`KMS_IO_BIT]; // R7
          `KMS_ADDR_EVT_MASK:  evt_mask_r <= wr_data[`KMS_EVT_W-1:0];
          `KMS_ADDR_INT_CTRL1: int_key_en_r <= wr_data[`KMS_INTC_KEY_EN];
          default: ;
        endcase
      end
      rd_data_r <= rd_stb ? rd_mux : 8'h00;
      // A new event in the clearing cycle survives the read
      evt_status_r <= (rd_status ? `KMS_RST_EVT : evt_status_r) | evt_set;
      irq_r        <= int_key_en_r && ((evt_status_r & evt_mask_r) != `KMS_RST_EVT); // R9
      wake_req_r   <= press_evt && wake_en_r && sleep_mode; // R3
    end
  end

endmodule // kms_top

// >>> sim/kms_key_matrix.sv
`timescale 1ns/1ps
module kms_key_matrix (
  input  wire  [3:0]  key_row_n,
  input  wire  [19:0] pressed,
  output logic [4:0]  key_col_n
);
  // ----
  // Switch matrix
  // ----
  always_comb begin
    // Pull-ups keep a column high unless a closed key meets a driven row
    key_col_n = 5'h1F;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 5; c++) begin
        if (!key_row_n[r] && pressed[r*5+c]) key_col_n[c] = 1'b0;
      end
    end
  end
endmodule // kms_key_matrix

// >>> sim/kms_top_sva.sv
`timescale 1ns/1ps
`include "kms_regs.vh"
module kms_top_sva #(
  parameter ROWS          = 4,
  parameter COLS          = 5,
  parameter SCAN_BASE_CYC = 2560,
  parameter LONG_BASE_CYC = 25000000
) (
  input wire            clk_sys,
  input wire            reset,
  input wire            ce,
  input wire [7:0]      addr,
  input wire [7:0]      wr_data,
  input wire            wr_stb,
  input wire            rd_stb,
  input wire [7:0]      rd_data_r,
  input wire [ROWS-1:0] key_row_n_r,
  input wire [COLS-1:0] key_col_n,
  input wire            extra_input_pin,
  input wire            extra_output_pin_r,
  input wire            sleep_mode,
  input wire            wake_req_r,
  input wire            irq_r
);
  // ----
  // Shadow of control bits
  // ----
  reg  scan_q;
  reg  int_en_q;
  reg  wake_q;
  wire rd_now = ce && rd_stb;
  wire wr_io  = ce && wr_stb && addr == `KMS_ADDR_EXTRA_IO;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      scan_q   <= 1'b0;
      int_en_q <= 1'b0;
      wake_q   <= 1'b0;
    end else if (ce && wr_stb) begin
      if (addr == `KMS_ADDR_CTRL1) scan_q <= wr_data[7];
      if (addr == `KMS_ADDR_INT_CTRL1) int_en_q <= wr_data[4];
      if (addr == `KMS_ADDR_CTRL2) wake_q <= wr_data[7];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ----
  // Checks
  // ----
  AST_RD_IDLE: assert property (ce && !rd_stb |=> rd_data_r == 8'h00)
    else $error("read data not cleared");
  AST_ROWS_OFF: assert property (!scan_q |=> &key_row_n_r)
    else $error("row driven while scan off");
  AST_ROWS_RUN: assert property (scan_q [*2] |-> !(&key_row_n_r))
    else $error("no row driven while scanning");
  AST_ONE_ROW: assert property (!(&key_row_n_r) |-> $onehot(~key_row_n_r))
    else $error("more than one row driven");
  AST_IRQ_GATE: assert property (!int_en_q |=> !irq_r)
    else $error("interrupt while disabled");
  AST_OUT_PIN: assert property (wr_io |=> {7'h00, extra_output_pin_r} == ($past(wr_data) & 8'h01))
    else $error("extra output not written");
  AST_OUT_HOLD: assert property (!wr_io |=> $stable(extra_output_pin_r))
    else $error("extra output changed");
  AST_RD_IO: assert property (rd_now && addr == `KMS_ADDR_EXTRA_IO |=>
    rd_data_r == {7'h00, $past(extra_input_pin)})
    else $error("extra input read wrong");
  AST_RD_C1B3: assert property (rd_now && addr == `KMS_ADDR_CTRL1 |=> !rd_data_r[3])
    else $error("control 1 bit 3 not zero");
  AST_RD_C2HI: assert property (rd_now && addr == `KMS_ADDR_CTRL2 |=> rd_data_r[6:4] == 3'h0)
    else $error("control 2 bits 6-4 not zero");
  AST_WAKE_GATE: assert property (!(wake_q && sleep_mode) [*2] |=> !wake_req_r)
    else $error("wake without enable and sleep");
  AST_WAKE_PULSE: assert property (wake_req_r |=> !wake_req_r)
    else $error("wake request too long");
  COV_IRQ: cover property (irq_r);
  COV_WAKE: cover property (wake_req_r);
  COV_RD_EVT: cover property (rd_now && addr == `KMS_ADDR_EVT_STATUS);
endmodule // kms_top_sva

bind kms_top kms_top_sva #(
  .ROWS(ROWS), .COLS(COLS), .SCAN_BASE_CYC(SCAN_BASE_CYC), .LONG_BASE_CYC(LONG_BASE_CYC)
) u_sva (
  .clk_sys(clk_sys), .reset(reset), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data_r(rd_data_r), .key_row_n_r(key_row_n_r), .key_col_n(key_col_n),
  .extra_input_pin(extra_input_pin), .extra_output_pin_r(extra_output_pin_r),
  .sleep_mode(sleep_mode), .wake_req_r(wake_req_r), .irq_r(irq_r)
);

// >>> sim/kms_top_tb_top.sv
`timescale 1ns/1ps
`include "kms_regs.vh"
module kms_top_tb_top;
  localparam SB = 8;
  localparam LB = 50;
  logic        clk_sys, reset, ce, wr_stb, rd_stb;
  logic        extra_input_pin, sleep_mode, extra_output_pin_r, wake_req_r, irq_r;
  logic [7:0]  addr, wr_data, rd_data_r, d;
  logic [3:0]  key_row_n_r;
  logic [4:0]  key_col_n;
  logic [19:0] pressed;
  int          miscompares, comparisons, wakes, per;
  time         t0, tf;
  kms_top #(.SCAN_BASE_CYC(SB), .LONG_BASE_CYC(LB)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data_r(rd_data_r), .key_row_n_r(key_row_n_r), .key_col_n(key_col_n),
    .extra_input_pin(extra_input_pin), .extra_output_pin_r(extra_output_pin_r),
    .sleep_mode(sleep_mode), .wake_req_r(wake_req_r), .irq_r(irq_r));
  kms_key_matrix u_mx (.key_row_n(key_row_n_r), .pressed(pressed), .key_col_n(key_col_n));
  // ----
  // Helpers
  // ----
  always @(posedge clk_sys) if (wake_req_r === 1'b1) wakes++;
  always @(negedge key_row_n_r[0]) begin
    per = ($time - tf) / 25;
    tf = $time;
  end
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rd_data_r;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk("reg", d, e);
  endtask
  task automatic wait_cnt(input logic [1:0] e);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(`KMS_ADDR_CTRL2);
      if (d[1:0] === e) break;
    end
    if (i == 3000) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk_sys);
    #1 chk("irq", irq_r, e);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    rdc(`KMS_ADDR_CTRL1, 8'h00);
    rdc(`KMS_ADDR_CTRL2, 8'h00);
    rdc(8'hC5, 8'h00);
    wr(`KMS_ADDR_CTRL1, 8'hFF);
    rdc(`KMS_ADDR_CTRL1, 8'hF7);
    wr(`KMS_ADDR_CTRL2, 8'hFF);
    rdc(`KMS_ADDR_CTRL2, 8'h8C);
    wr(`KMS_ADDR_CTRL2, 8'h00);
  endtask
  task automatic t_io;
    extra_input_pin <= 1'b1;
    rdc(`KMS_ADDR_EXTRA_IO, 8'h01);
    extra_input_pin <= 1'b0;
    rdc(`KMS_ADDR_EXTRA_IO, 8'h00);
    wr(`KMS_ADDR_EXTRA_IO, 8'h01);
    irq_is(1'b0);
    chk("gpo", extra_output_pin_r, 1'b1);
  endtask
  task automatic t_freq;
    for (int f = 0; f < 8; f++) begin
      wr(`KMS_ADDR_CTRL1, 8'h80 + f[7:0]);
      repeat ((SB << f) * 3) @(posedge clk_sys);
      chk("period", per, SB << f);
    end
  endtask
  task automatic t_press;
    wr(`KMS_ADDR_EVT_MASK, 8'h03);
    wr(`KMS_ADDR_CTRL1, 8'h80);
    pressed <= 20'h82082;
    t0 = $time;
    wait_cnt(2'h3);
    chk("deb4", ($time - t0) / 25 inside {[24:56]}, 1'b1);
    chk("irq", irq_r, 1'b0);
    rdc(`KMS_ADDR_CODE0, 8'h01);
    rdc(`KMS_ADDR_CODE1, 8'h12);
    rdc(`KMS_ADDR_CODE2, 8'h23);
    wr(`KMS_ADDR_INT_CTRL1, 8'h10);
    irq_is(1'b1);
    wr(`KMS_ADDR_EVT_MASK, 8'h00);
    irq_is(1'b0);
    wr(`KMS_ADDR_EVT_MASK, 8'h01);
    irq_is(1'b1);
    rdc(`KMS_ADDR_EVT_STATUS, 8'h01);
    irq_is(1'b0);
    pressed <= 20'h00080;
    wait_cnt(2'h1);
    rdc(`KMS_ADDR_CODE0, 8'h12);
    pressed <= 20'h0;
    wait_cnt(2'h0);
  endtask
  task automatic t_long;
    wr(`KMS_ADDR_CTRL2, 8'h04);
    wr(`KMS_ADDR_CTRL1, 8'hC0);
    pressed <= 20'h00001;
    wait_cnt(2'h1);
    rd(`KMS_ADDR_EVT_STATUS);
    repeat (LB * 2 - 20) @(posedge clk_sys);
    rd(`KMS_ADDR_EVT_STATUS);
    chk("long early", d[1], 1'b0);
    repeat (40) @(posedge clk_sys);
    rd(`KMS_ADDR_EVT_STATUS);
    chk("long", d[1], 1'b1);
    pressed <= 20'h0;
    wait_cnt(2'h0);
  endtask
  task automatic t_wake;
    sleep_mode <= 1'b1;
    wr(`KMS_ADDR_CTRL2, 8'h80);
    wr(`KMS_ADDR_CTRL1, 8'h90);
    pressed <= 20'h80000;
    t0 = $time;
    wait_cnt(2'h1);
    chk("deb8", ($time - t0) / 25 inside {[56:88]}, 1'b1);
    rdc(`KMS_ADDR_CODE0, 8'h34);
    chk("wake", wakes, 1);
    pressed <= 20'h0;
    wait_cnt(2'h0);
    wr(`KMS_ADDR_CTRL2, 8'h00);
    pressed <= 20'h80000;
    wait_cnt(2'h1);
    repeat (3) @(posedge clk_sys);
    chk("no wake", wakes, 1);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    {reset, ce} = 2'b11;
    {wr_stb, rd_stb, extra_input_pin, sleep_mode} = 4'h0;
    addr = 8'h00;
    wr_data = 8'h00;
    pressed = 20'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_io();
    t_freq();
    t_press();
    t_long();
    t_wake();
    print_verdict();
  end
endmodule // kms_top_tb_top
